// [mid_pkg.sv]
// constants, register map and types for the machine input decoder
// Summary of operation
// - key one low refuses tool/offset writes
// - refused tool write raises protect violation
// - all keys read high after power-up
// - key two low refuses parameter/variable writes
// - refused parameter write raises protect violation
// - key three low refuses program edits
// - refused program edit raises protect violation
// - view request selects running program
// - inclined enable switches inclined control
// - inclined changes wait for motion stop
// - inclined change in auto stops block
// - no-comp high leaves basic axis still
// - skip high skips leading-slash blocks
// - mid-block slash never skips
// - skip low executes slash blocks
// - axis code five bits, one-based
// - code ignored without qualifier
// - code steers first handwheel only
package mid_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_WRITE_REQ = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_BLOCK = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_HANDLE = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_VIOL_CLR = 12'h014;
  localparam logic [7:0] SLASH_CHAR = 8'h2F;
  localparam int AXIS_CODE_W = 5;
  localparam int AXIS_SEL_W = 4;
  localparam logic [AXIS_CODE_W-1:0] AXIS_COUNT = 5'h04;
  localparam logic [2:0] KEYS_RESET = 3'h7;
  localparam int WR_TOOL = 0;
  localparam int WR_PARAM = 1;
  localparam int WR_PROG = 2;
  localparam int ST_VIOL = 0;
  localparam int ST_INCL = 1;
  localparam int ST_NOCOMP = 2;
  localparam int ST_BSTOP = 3;
  localparam int ST_VIEW = 4;
  localparam int ST_SKIP = 5;
  localparam int ST_KEYS = 8;
  localparam int ST_AXIS = 12;
  localparam int CT_MOVING = 0;
  localparam int CT_AUTO = 1;
  localparam int CT_MANINC = 2;
  typedef enum logic [1:0] {
    MID_IDLE = 2'b00,
    MID_SETUP = 2'b01,
    MID_ACCESS = 2'b10
  } mid_apb_e;
endpackage : mid_pkg

// [mid_sync.sv]
// two-flop synchroniser for a group of machine input bits
`timescale 1ns/1ps
module mid_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // scan clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [W-1:0] d, // asynchronous input bits
  output logic [W-1:0] q // synchronised bits
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mid_sync_s;
  mid_sync_s st_q;
  mid_sync_s st_d;
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= {INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule : mid_sync

// [mid_top.sv]
// machine input decoder: protect keys, skip, view, inclined axis, first handle
`timescale 1ns/1ps
module mid_top
  import mid_pkg::*;
(
  input wire logic REF_CLK, // scan clock
  input wire logic RST, // synchronous reset, active high
  input wire logic TOOL_DATA_PROTECT_N, // key one, low protects tool data
  input wire logic PARAM_VAR_PROTECT_N, // key two, low protects parameters
  input wire logic PROGRAM_EDIT_PROTECT_N, // key three, low protects programs
  input wire logic RUNNING_PROGRAM_VIEW_REQ, // show running program
  input wire logic INCLINED_ENABLE, // inclined axis control request
  input wire logic INCLINED_NO_COMP, // no basic axis compensation
  input wire logic SLASH_BLOCK_SKIP, // optional block skip
  input wire logic [mid_pkg::AXIS_CODE_W-1:0] HANDLE_ONE_AXIS_CODE, // first handle axis
  input wire logic HANDLE_ONE_QUALIFIER, // first handle valid
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [mid_pkg::ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [mid_pkg::DATA_W-1:0] PWDATA, // apb write data
  output logic [mid_pkg::DATA_W-1:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  output logic PROTECT_VIOLATION, // sticky protect violation
  output logic VIEW_RUNNING_PROGRAM, // edit view shows running program
  output logic INCLINED_ACTIVE, // inclined control in force
  output logic BASIC_AXIS_COMP, // basic axis follows inclined moves
  output logic BLOCK_STOP_REQ, // stop at end of current block
  output logic [mid_pkg::AXIS_SEL_W-1:0] HANDLE_ONE_AXIS_SEL // one-hot axis for handle one
);
  import mid_pkg::*;

  logic [2:0] keys_s;
  logic [2:0] misc_s;
  logic [AXIS_CODE_W:0] hnd_s;

  mid_sync #(.W(3), .INIT(KEYS_RESET)) u_keys (
    .clk(REF_CLK),
    .rst(RST),
    .d({PROGRAM_EDIT_PROTECT_N, PARAM_VAR_PROTECT_N, TOOL_DATA_PROTECT_N}),
    .q(keys_s)
  );
  mid_sync #(.W(3), .INIT(3'h0)) u_misc (
    .clk(REF_CLK),
    .rst(RST),
    .d({SLASH_BLOCK_SKIP, INCLINED_NO_COMP, INCLINED_ENABLE}),
    .q(misc_s)
  );
  mid_sync #(.W(AXIS_CODE_W + 1), .INIT('0)) u_hnd (
    .clk(REF_CLK),
    .rst(RST),
    .d({HANDLE_ONE_QUALIFIER, HANDLE_ONE_AXIS_CODE}),
    .q(hnd_s)
  );
  logic view_s;
  mid_sync #(.W(1), .INIT(1'b0)) u_view (
    .clk(REF_CLK),
    .rst(RST),
    .d(RUNNING_PROGRAM_VIEW_REQ),
    .q(view_s)
  );

  typedef struct packed {
    mid_apb_e apb;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
    logic [2:0] ctrl;
    logic [7:0] block_char;
    logic skip_block;
    logic viol;
    logic view;
    logic incl;
    logic nocomp;
    logic incl_seen;
    logic bstop;
    logic comp;
    logic [AXIS_SEL_W-1:0] sel;
    logic [AXIS_CODE_W-1:0] code;
  } mid_top_s;

  mid_top_s st_q;
  mid_top_s st_d;
  logic acc;
  logic wr;
  logic rd;
  logic refused;

  always_comb begin
    st_d = st_q;
    acc = st_q.apb == MID_SETUP && PSEL && PENABLE;
    wr = acc && PWRITE;
    rd = acc && !PWRITE;
    refused = 1'b0;
    st_d.ready = 1'b0;
    st_d.slverr = 1'b0;
    st_d.rdata = '0;
    unique case (st_q.apb)
      MID_IDLE: begin
        if (PSEL && !PENABLE) begin
          st_d.apb = MID_SETUP;
        end
      end
      MID_SETUP: begin
        if (PSEL && PENABLE) begin
          st_d.apb = MID_ACCESS;
          st_d.ready = 1'b1;
        end else if (!PSEL) begin
          st_d.apb = MID_IDLE;
        end
      end
      MID_ACCESS: begin
        st_d.apb = (PSEL && !PENABLE) ? MID_SETUP : MID_IDLE;
      end
      default: begin
        st_d.apb = MID_IDLE;
      end
    endcase
    if (wr) begin
      unique case (PADDR)
        OFS_CTRL: st_d.ctrl = PWDATA[2:0];
        OFS_WRITE_REQ: begin
          refused = (PWDATA[WR_TOOL] && !keys_s[0])
            || (PWDATA[WR_PARAM] && !keys_s[1])
            || (PWDATA[WR_PROG] && !keys_s[2]);
        end
        OFS_BLOCK: begin
          st_d.block_char = PWDATA[7:0];
          // only a leading slash counts, and only while skip is high
          st_d.skip_block = misc_s[2] && PWDATA[7:0] == SLASH_CHAR;
        end
        OFS_STATUS, OFS_HANDLE: st_d.slverr = 1'b0;
        OFS_VIOL_CLR: begin
          if (PWDATA[ST_VIOL]) st_d.viol = 1'b0;
          if (PWDATA[ST_BSTOP]) st_d.bstop = 1'b0;
        end
        default: st_d.slverr = 1'b1;
      endcase
    end
    if (rd) begin
      unique case (PADDR)
        OFS_CTRL: st_d.rdata = {29'h0000_0000, st_q.ctrl};
        OFS_STATUS: begin
          st_d.rdata[ST_VIOL] = st_q.viol;
          st_d.rdata[ST_INCL] = st_q.incl;
          st_d.rdata[ST_NOCOMP] = st_q.nocomp;
          st_d.rdata[ST_BSTOP] = st_q.bstop;
          st_d.rdata[ST_VIEW] = st_q.view;
          st_d.rdata[ST_SKIP] = st_q.skip_block;
          st_d.rdata[ST_KEYS +: 3] = keys_s;
          st_d.rdata[ST_AXIS +: AXIS_SEL_W] = st_q.sel;
        end
        OFS_WRITE_REQ, OFS_VIOL_CLR: st_d.rdata = '0;
        OFS_BLOCK: st_d.rdata = {23'h00_0000, st_q.skip_block, st_q.block_char};
        OFS_HANDLE: st_d.rdata = {27'h000_0000, st_q.code};
        default: st_d.slverr = 1'b1;
      endcase
    end
    // set wins over clear
    if (refused) st_d.viol = 1'b1;
    st_d.view = view_s;
    // inclined settings follow inputs only while no axis moves
    if (!st_q.ctrl[CT_MOVING]) begin
      st_d.incl = misc_s[0];
      st_d.nocomp = misc_s[1];
    end
    // compensate basic axis only during manual inclined moves without no-comp
    st_d.comp = st_d.incl && st_d.ctrl[CT_MANINC] && !st_d.nocomp;
    st_d.incl_seen = misc_s[0];
    if (misc_s[0] != st_q.incl_seen && st_q.ctrl[CT_AUTO]) begin
      st_d.bstop = 1'b1;
    end
    st_d.code = hnd_s[AXIS_CODE_W-1:0];
    st_d.sel = '0;
    if (hnd_s[AXIS_CODE_W]) begin
      for (int i = 0; i < AXIS_SEL_W; i++) begin
        // one-based code; zero and out-of-range pick nothing
        if (hnd_s[AXIS_CODE_W-1:0] == AXIS_CODE_W'(i + 1)
            && hnd_s[AXIS_CODE_W-1:0] <= AXIS_COUNT) begin
          st_d.sel[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= '0;
      st_q.apb <= MID_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA = st_q.rdata;
  assign PREADY = st_q.ready;
  assign PSLVERR = st_q.slverr;
  assign PROTECT_VIOLATION = st_q.viol;
  assign VIEW_RUNNING_PROGRAM = st_q.view;
  assign INCLINED_ACTIVE = st_q.incl;
  assign BASIC_AXIS_COMP = st_q.comp;
  assign BLOCK_STOP_REQ = st_q.bstop;
  assign HANDLE_ONE_AXIS_SEL = st_q.sel;
endmodule : mid_top

// [mid_checker.sv]
// concurrent checks on the machine input decoder ports
`timescale 1ns/1ps
module mid_checker
  import mid_pkg::*;
(
  input wire logic REF_CLK, // scan clock
  input wire logic RST, // synchronous reset, active high
  input wire logic TOOL_DATA_PROTECT_N, // key one
  input wire logic PARAM_VAR_PROTECT_N, // key two
  input wire logic PROGRAM_EDIT_PROTECT_N, // key three
  input wire logic RUNNING_PROGRAM_VIEW_REQ, // view request
  input wire logic HANDLE_ONE_QUALIFIER, // first handle valid
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic PROTECT_VIOLATION, // sticky violation
  input wire logic VIEW_RUNNING_PROGRAM, // view output
  input wire logic INCLINED_ACTIVE, // inclined control in force
  input wire logic BASIC_AXIS_COMP, // basic axis compensation
  input wire logic BLOCK_STOP_REQ, // block stop output
  input wire logic [mid_pkg::ADDR_W-1:0] PADDR, // apb address
  input wire logic [mid_pkg::DATA_W-1:0] PWDATA, // apb write data
  input wire logic [mid_pkg::AXIS_SEL_W-1:0] HANDLE_ONE_AXIS_SEL // axis select
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire wq = PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_WRITE_REQ;
  property p_tool_data_protect_n;
    wq && PWDATA[WR_TOOL] && !TOOL_DATA_PROTECT_N |-> ##[0:2] PROTECT_VIOLATION;
  endproperty
  a_tool_data_protect_n: assert property (p_tool_data_protect_n) else $error("tool write not flagged");
  property p_param_var_protect_n;
    wq && PWDATA[WR_PARAM] && !PARAM_VAR_PROTECT_N |-> ##[0:2] PROTECT_VIOLATION;
  endproperty
  a_param_var_protect_n: assert property (p_param_var_protect_n) else $error("param write not flagged");
  property p_program_edit_protect_n;
    wq && PWDATA[WR_PROG] && !PROGRAM_EDIT_PROTECT_N |-> ##[0:2] PROTECT_VIOLATION;
  endproperty
  a_program_edit_protect_n: assert property (p_program_edit_protect_n) else $error("edit not flagged");
  property p_hold;
    PROTECT_VIOLATION && !PSEL && !$past(PSEL) |=> PROTECT_VIOLATION;
  endproperty
  a_hold: assert property (p_hold) else $error("violation dropped");
  property p_view;
    $rose(RUNNING_PROGRAM_VIEW_REQ) |-> ##[2:4] VIEW_RUNNING_PROGRAM;
  endproperty
  a_view: assert property (p_view) else $error("view not selected");
  property p_axis;
    HANDLE_ONE_AXIS_SEL != 0 |-> $onehot(HANDLE_ONE_AXIS_SEL) && $past(HANDLE_ONE_QUALIFIER, 3);
  endproperty
  a_axis: assert property (p_axis) else $error("axis without qualifier");
  property p_comp;
    BASIC_AXIS_COMP |-> INCLINED_ACTIVE;
  endproperty
  a_comp: assert property (p_comp) else $error("comp without inclined");
  property p_ready;
    PREADY |-> PSEL && PENABLE ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("bad ready pulse");
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_viol: cover property (PROTECT_VIOLATION);
  c_stop: cover property (BLOCK_STOP_REQ);
  c_axis4: cover property (HANDLE_ONE_AXIS_SEL == 4'h8);
endmodule : mid_checker

// [mid_seq_model.sv]
// sequence program model driving the first handle code and qualifier
`timescale 1ns/1ps
module mid_seq_model
  import mid_pkg::*;
(
  input wire logic clk, // scan clock
  input wire logic go, // handle selection wanted
  input wire logic qual_first, // qualifier before code
  input wire logic [mid_pkg::AXIS_CODE_W-1:0] axis, // axis wanted
  output logic [mid_pkg::AXIS_CODE_W-1:0] code, // to the decoder
  output logic qual // to the decoder
);
  logic step = 1'h0;
  initial code = 5'h00;
  initial qual = 1'h0;
  always @(posedge clk) begin
    step <= go;
    if (go && (qual_first || step)) qual <= 1'h1;
    if (go && (!qual_first || step)) code <= axis;
    // the code stays valid after release, so only the qualifier gates it
    if (!go) qual <= 1'h0;
  end
endmodule : mid_seq_model

// [mid_top_tb.sv]
// self-checking bench for the machine input decoder
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t mismatch", $time); end end
module mid_top_tb;
  import mid_pkg::*;
  logic REF_CLK = 1'h0, RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic TOOL_DATA_PROTECT_N = 1'h1, PARAM_VAR_PROTECT_N = 1'h1, PROGRAM_EDIT_PROTECT_N = 1'h1;
  logic RUNNING_PROGRAM_VIEW_REQ = 1'h0, INCLINED_ENABLE = 1'h0, INCLINED_NO_COMP = 1'h0;
  logic SLASH_BLOCK_SKIP = 1'h0, HANDLE_ONE_QUALIFIER, go = 1'h0, qf = 1'h0, e;
  logic PREADY, PSLVERR, PROTECT_VIOLATION, VIEW_RUNNING_PROGRAM, INCLINED_ACTIVE;
  logic BASIC_AXIS_COMP, BLOCK_STOP_REQ;
  logic [4:0] HANDLE_ONE_AXIS_CODE, axis = 5'h00;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic [3:0] HANDLE_ONE_AXIS_SEL;
  int n_mismatch = 0, checks = 0;
  always #4 REF_CLK = ~REF_CLK;
  mid_top u_dut (.*);
  mid_seq_model u_seq (.clk(REF_CLK), .go(go), .qual_first(qf), .axis(axis),
    .code(HANDLE_ONE_AXIS_CODE), .qual(HANDLE_ONE_QUALIFIER));
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : tick
  // one apb transfer, then one idle cycle
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'h1 && n < 40);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    if (n >= 40) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge REF_CLK);
  endtask : xfer
  initial begin
    tick(12);
    RST <= 1'h0;
    xfer(1'h0, OFS_STATUS, 32'h0);
    `CHK(r[ST_KEYS+:3], KEYS_RESET)
    for (int i = 0; i < 3; i++) begin
      {PROGRAM_EDIT_PROTECT_N, PARAM_VAR_PROTECT_N, TOOL_DATA_PROTECT_N} <= ~(3'h1 << i);
      tick(6);
      xfer(1'h1, OFS_WRITE_REQ, 32'h1 << ((i + 1) % 3));
      `CHK(PROTECT_VIOLATION, 1'h0)
      xfer(1'h1, OFS_WRITE_REQ, 32'h1 << i);
      `CHK(PROTECT_VIOLATION, 1'h1)
      {PROGRAM_EDIT_PROTECT_N, PARAM_VAR_PROTECT_N, TOOL_DATA_PROTECT_N} <= 3'h7;
      xfer(1'h1, OFS_VIOL_CLR, 32'h1);
      `CHK(PROTECT_VIOLATION, 1'h0)
    end
    for (int v = 1; v >= 0; v--) begin
      RUNNING_PROGRAM_VIEW_REQ <= v[0];
      tick(6);
      `CHK(VIEW_RUNNING_PROGRAM, v[0])
    end
    for (int k = 0; k < 4; k++) begin
      SLASH_BLOCK_SKIP <= k[1];
      tick(6);
      xfer(1'h1, OFS_BLOCK, k[0] ? {24'h0, SLASH_CHAR} : 32'h4E);
      xfer(1'h0, OFS_BLOCK, 32'h0);
      `CHK(r[8], k[1] & k[0])
    end
    xfer(1'h1, OFS_CTRL, 32'h1);
    INCLINED_ENABLE <= 1'h1;
    tick(6);
    `CHK(INCLINED_ACTIVE, 1'h0)
    xfer(1'h1, OFS_CTRL, 32'h4);
    tick(4);
    `CHK(INCLINED_ACTIVE, 1'h1)
    `CHK(BASIC_AXIS_COMP, 1'h1)
    xfer(1'h1, OFS_CTRL, 32'h5);
    INCLINED_NO_COMP <= 1'h1;
    tick(6);
    `CHK(BASIC_AXIS_COMP, 1'h1)
    xfer(1'h1, OFS_CTRL, 32'h4);
    tick(4);
    `CHK(BASIC_AXIS_COMP, 1'h0)
    xfer(1'h1, OFS_CTRL, 32'h2);
    INCLINED_ENABLE <= 1'h0;
    tick(6);
    `CHK(BLOCK_STOP_REQ, 1'h1)
    `CHK(INCLINED_ACTIVE, 1'h0)
    xfer(1'h1, OFS_VIOL_CLR, 32'h8);
    `CHK(BLOCK_STOP_REQ, 1'h0)
    for (int c = 0; c < 12; c++) begin
      axis <= 5'(c / 2);
      qf <= c[0];
      go <= 1'h1;
      tick(6);
      `CHK(HANDLE_ONE_AXIS_SEL, (c > 1 && c < 10) ? 4'(1 << (c / 2 - 1)) : 4'h0)
      go <= 1'h0;
      tick(6);
      `CHK(HANDLE_ONE_AXIS_SEL, 4'h0)
    end
    xfer(1'h0, 12'hFFC, 32'h0);
    `CHK(e, 1'h1)
    `CHK(r, 32'h0)
    report_and_stop();
  end
endmodule : mid_top_tb
bind mid_top mid_checker u_chk (.*);
